// ==== core/flash_write_erase_control_defines.svh ====
`ifndef FLASH_WRITE_ERASE_CONTROL_DEFINES_SVH
`define FLASH_WRITE_ERASE_CONTROL_DEFINES_SVH

// Register offsets in the special-function-register space.
`define SFR_RESET_CAUSE 8'hef
`define SFR_FLASH_UNLOCK_KEY 8'hd6
`define SFR_PROGRAM_STORE_CONTROL 8'hd7

// Program store control fields.
`define STORE_WRITE_EN_BIT 0
`define STORE_ERASE_EN_BIT 1

// Reset cause fields.
`define RC_FLASH_ERROR_BIT 6
`define RC_COMPARATOR_BIT 5
`define RC_SOFTWARE_BIT 4
`define RC_WATCHDOG_BIT 3
`define RC_CLOCK_MISSING_BIT 2
`define RC_POWER_ON_BIT 1
`define RC_PIN_BIT 0
`define RC_RESET_VALUE 8'h02

// Unlock key codes, taken in this order.
`define KEY_FIRST_CODE 8'ha5
`define KEY_SECOND_CODE 8'hf1

// Read-back codes of the unlock key register.
`define KEY_READ_IDLE 8'h00
`define KEY_READ_FIRST 8'h01
`define KEY_READ_OPEN 8'h02
`define KEY_READ_LOCKOUT 8'h03

// Timing: clock period and flash operation times.
`define CLK_PERIOD_NS 50
`define FLASH_WRITE_TIME_NS 40000
`define FLASH_ERASE_TIME_NS 20000000
`define FLASH_WRITE_CYCLES \
	((`FLASH_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLASH_ERASE_CYCLES \
	((`FLASH_ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLASH_CNT_W 20
`define SYS_RESET_HOLD_CYCLES 3'd4
`define SYS_RESET_HOLD_W 3

// Flash geometry.
`define FLASH_ADDR_W 13
`define FLASH_PAGE_W 9

`endif

// ==== core/flash_write_erase_control_pkg.sv ====
`default_nettype none
package flash_write_erase_control_pkg;

	// Progress of the two-code unlock sequence.
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_FIRST,
		KEY_OPEN,
		KEY_LOCKOUT
	} key_state_t;

endpackage
`default_nettype wire

// ==== core/flash_array.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_write_erase_control_defines.svh"
module flash_array #(
	parameter int ADDR_W = `FLASH_ADDR_W,
	parameter int PAGE_W = `FLASH_PAGE_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_i,
	input wire logic erase_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] data_i,
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic [7:0] rd_data_o
);
	localparam int DEPTH = 1 << ADDR_W;

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [7:0] rd;
	} array_state_t;

	array_state_t q;
	array_state_t d;
	logic [DEPTH-1:0][7:0] mem_n;

	// Each entry decides its own next value; an erase hits the whole page.
	for (genvar g = 0; g < DEPTH; g++) begin : g_entry
		localparam logic [ADDR_W-1:0] IDX = ADDR_W'(g);
		assign mem_n[g] =
			(erase_i && IDX[ADDR_W-1:PAGE_W] == addr_i[ADDR_W-1:PAGE_W]) ?
			8'hff :
			(wr_i && IDX == addr_i) ? (q.mem[g] & data_i) :
			q.mem[g];
	end

	// Reads are registered so the code port is driven from a flop.
	always_comb begin
		d = q;
		d.mem = mem_n;
		d.rd = q.mem[rd_addr_i];
	end

	// Power-on leaves the array erased, which is its blank state.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '{mem: {DEPTH{8'hff}}, rd: 8'hff};
		end else begin
			q <= d;
		end
	end

	assign rd_data_o = q.rd;

	// Helper copies of the last operation for the checks below.
	logic last_wr;
	logic last_erase;
	logic [ADDR_W-1:0] last_addr;
	logic [7:0] last_old;
	logic [7:0] last_data;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_wr <= 1'b0;
			last_erase <= 1'b0;
			last_addr <= '0;
			last_old <= 8'h00;
			last_data <= 8'h00;
		end else begin
			last_wr <= wr_i && !erase_i;
			last_erase <= erase_i;
			last_addr <= addr_i;
			last_old <= q.mem[addr_i];
			last_data <= data_i;
		end
	end

	chk_write_and_only: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		last_wr |-> q.mem[last_addr] == (last_old & last_data))
		else $error("Flash byte write did not AND old and new data.");

	chk_erase_whole_page: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		last_erase |-> (q.mem[last_addr] == 8'hff &&
		q.mem[{last_addr[ADDR_W-1:PAGE_W], PAGE_W'(0)}] == 8'hff &&
		q.mem[{last_addr[ADDR_W-1:PAGE_W], {PAGE_W{1'b1}}}] == 8'hff))
		else $error("Page erase left a byte that is not all ones.");

endmodule // flash_array
`default_nettype wire

// ==== core/flash_write_erase_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_write_erase_control_defines.svh"
module flash_write_erase_control
	import flash_write_erase_control_pkg::*;
#(
	parameter int ADDR_W = `FLASH_ADDR_W,
	parameter int PAGE_W = `FLASH_PAGE_W,
	parameter int ERASE_CYCLES = `FLASH_ERASE_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic pin_reset_n_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic ext_move_wr_i,
	input wire logic [15:0] ext_move_addr_i,
	input wire logic [7:0] ext_move_data_i,
	output logic xram_we_o,
	output logic [15:0] xram_addr_o,
	output logic [7:0] xram_data_o,
	input wire logic [ADDR_W-1:0] code_addr_i,
	output logic [7:0] code_data_o,
	input wire logic watchdog_reset_i,
	input wire logic clock_missing_i,
	input wire logic comparator_trip_i,
	input wire logic vdd_low_i,
	output logic stall_o,
	output logic sys_reset_o
);
	localparam int WRITE_CYCLES = `FLASH_WRITE_CYCLES;
	localparam logic [`FLASH_CNT_W-1:0] WRITE_LAST =
		`FLASH_CNT_W'(WRITE_CYCLES - 1);
	localparam logic [`FLASH_CNT_W-1:0] ERASE_LAST =
		`FLASH_CNT_W'(ERASE_CYCLES - 1);

	typedef struct packed {
		key_state_t key;
		logic wr_en;
		logic erase_en;
		logic busy;
		logic is_erase;
		logic [`FLASH_CNT_W-1:0] cnt;
		logic [7:0] cause;
		logic cmp_en;
		logic mcd_en;
		logic vdd_en;
		logic sys_rst;
		logic [`SYS_RESET_HOLD_W-1:0] hold;
		logic [7:0] rdata;
		logic xram_we;
		logic [15:0] xram_addr;
		logic [7:0] xram_data;
		logic flash_wr;
		logic flash_erase;
		logic [ADDR_W-1:0] flash_addr;
		logic [7:0] flash_data;
		logic pin_meta;
		logic pin_sync;
	} ctrl_state_t;

	ctrl_state_t q;
	ctrl_state_t d;
	logic [1:0] rst_sync_q;
	logic rst_n;

	// The reset is released through two flops so its removal is clean.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Decoded strobes of the register port and the move path.
	logic wr_key;
	logic wr_ctrl;
	logic wr_cause;
	logic flash_try;
	assign wr_key = sfr_wr_i && sfr_addr_i == `SFR_FLASH_UNLOCK_KEY;
	assign wr_ctrl = sfr_wr_i && sfr_addr_i == `SFR_PROGRAM_STORE_CONTROL;
	assign wr_cause = sfr_wr_i && sfr_addr_i == `SFR_RESET_CAUSE;
	assign flash_try = ext_move_wr_i && q.wr_en && !q.busy;

	// All next-state logic of the controller lives here.
	always_comb begin
		logic [7:0] ev;
		logic [7:0] key_rd;
		ev = 8'h00;
		key_rd = `KEY_READ_IDLE;
		d = q;
		d.flash_wr = 1'b0;
		d.flash_erase = 1'b0;
		d.xram_we = 1'b0;
		d.pin_meta = pin_reset_n_i;
		d.pin_sync = q.pin_meta;

		// Reset sources; disabled sources are masked by their enables.
		ev[`RC_SOFTWARE_BIT] = wr_cause && sfr_wdata_i[`RC_SOFTWARE_BIT];
		ev[`RC_FLASH_ERROR_BIT] = flash_try && q.key != KEY_OPEN;
		ev[`RC_WATCHDOG_BIT] = watchdog_reset_i;
		ev[`RC_CLOCK_MISSING_BIT] = clock_missing_i && q.mcd_en;
		ev[`RC_COMPARATOR_BIT] = comparator_trip_i && q.cmp_en;
		ev[`RC_POWER_ON_BIT] = vdd_low_i && q.vdd_en;
		ev[`RC_PIN_BIT] = !q.pin_sync;

		unique case (q.key)
			KEY_IDLE: key_rd = `KEY_READ_IDLE;
			KEY_FIRST: key_rd = `KEY_READ_FIRST;
			KEY_OPEN: key_rd = `KEY_READ_OPEN;
			KEY_LOCKOUT: key_rd = `KEY_READ_LOCKOUT;
		endcase

		// Read data answers one cycle after the strobe; unmapped reads zero.
		d.rdata = 8'h00;
		if (sfr_rd_i) begin
			unique case (sfr_addr_i)
				`SFR_RESET_CAUSE: d.rdata = q.cause;
				`SFR_FLASH_UNLOCK_KEY: d.rdata = key_rd;
				`SFR_PROGRAM_STORE_CONTROL:
					d.rdata = {6'b000000, q.erase_en, q.wr_en};
				default: d.rdata = 8'h00;
			endcase
		end

		if (!q.sys_rst && |ev) begin
			// A new system reset: record why and clear all control state except the supply enable.
			d.cause = ev;
			d.sys_rst = 1'b1;
			d.hold = `SYS_RESET_HOLD_CYCLES - 3'd1;
			d.key = KEY_IDLE;
			d.wr_en = 1'b0;
			d.erase_en = 1'b0;
			d.busy = 1'b0;
			d.is_erase = 1'b0;
			d.cnt = '0;
			d.cmp_en = 1'b0;
			d.mcd_en = 1'b0;
		end else if (q.sys_rst) begin
			// Hold the system in reset; requests are ignored meanwhile.
			if (q.hold == '0) begin
				d.sys_rst = 1'b0;
			end else begin
				d.hold = q.hold - 3'd1;
			end
		end else begin
			if (wr_ctrl) begin
				d.wr_en = sfr_wdata_i[`STORE_WRITE_EN_BIT];
				d.erase_en = sfr_wdata_i[`STORE_ERASE_EN_BIT];
			end
			// Only the enable bits are writable; flags stay as captured.
			if (wr_cause) begin
				d.cmp_en = sfr_wdata_i[`RC_COMPARATOR_BIT];
				d.mcd_en = sfr_wdata_i[`RC_CLOCK_MISSING_BIT];
				d.vdd_en = sfr_wdata_i[`RC_POWER_ON_BIT];
			end
			// Key writes are ignored while an operation runs.
			if (wr_key && !q.busy) begin
				unique case (q.key)
					KEY_IDLE: d.key = (sfr_wdata_i == `KEY_FIRST_CODE) ?
						KEY_FIRST : KEY_LOCKOUT;
					KEY_FIRST: d.key = (sfr_wdata_i == `KEY_SECOND_CODE) ?
						KEY_OPEN : KEY_LOCKOUT;
					KEY_OPEN: d.key = KEY_LOCKOUT;
					KEY_LOCKOUT: d.key = KEY_LOCKOUT;
				endcase
			end
			// One move write starts one byte write or one page erase.
			if (flash_try && q.key == KEY_OPEN) begin
				d.busy = 1'b1;
				d.is_erase = q.erase_en;
				d.cnt = q.erase_en ? ERASE_LAST : WRITE_LAST;
				d.flash_wr = !q.erase_en;
				d.flash_erase = q.erase_en;
				d.flash_addr = ext_move_addr_i[ADDR_W-1:0];
				d.flash_data = ext_move_data_i;
			end else if (ext_move_wr_i && !q.wr_en) begin
				d.xram_we = 1'b1;
				d.xram_addr = ext_move_addr_i;
				d.xram_data = ext_move_data_i;
			end
			// Self-timed completion; the key is spent by the operation.
			if (q.busy) begin
				if (q.cnt == '0) begin
					d.busy = 1'b0;
					d.key = KEY_IDLE;
				end else begin
					d.cnt = q.cnt - `FLASH_CNT_W'(1);
				end
			end
		end
	end

	// The power-on copy starts out of system reset with the power-on flag set.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{key: KEY_IDLE, wr_en: 1'b0, erase_en: 1'b0,
				busy: 1'b0, is_erase: 1'b0, cnt: '0, cause: `RC_RESET_VALUE,
				cmp_en: 1'b0, mcd_en: 1'b0, vdd_en: 1'b1, sys_rst: 1'b0,
				hold: '0, rdata: 8'h00, xram_we: 1'b0, xram_addr: 16'h0000,
				xram_data: 8'h00, flash_wr: 1'b0, flash_erase: 1'b0,
				flash_addr: '0, flash_data: 8'h00, pin_meta: 1'b1,
				pin_sync: 1'b1};
		end else begin
			q <= d;
		end
	end

	// The array keeps its contents across system resets, like real flash.
	flash_array #(
		.ADDR_W(ADDR_W),
		.PAGE_W(PAGE_W)
	) u_array (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.wr_i(q.flash_wr),
		.erase_i(q.flash_erase),
		.addr_i(q.flash_addr),
		.data_i(q.flash_data),
		.rd_addr_i(code_addr_i),
		.rd_data_o(code_data_o)
	);

	// Outputs come straight from the state flops.
	assign sfr_rdata_o = q.rdata;
	assign xram_we_o = q.xram_we;
	assign xram_addr_o = q.xram_addr;
	assign xram_data_o = q.xram_data;
	assign stall_o = q.busy;
	assign sys_reset_o = q.sys_rst;

	chk_bad_key_locks: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		(wr_key && !q.sys_rst && !q.busy && q.key == KEY_IDLE &&
		sfr_wdata_i != `KEY_FIRST_CODE && !ext_move_wr_i && !sfr_wr_i == 1'b0
		&& !watchdog_reset_i && !clock_missing_i && !comparator_trip_i &&
		!vdd_low_i && q.pin_sync) |=> q.key == KEY_LOCKOUT)
		else $error("Wrong first key code did not lock out flash.");

	chk_early_try_resets: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		(flash_try && q.key != KEY_OPEN && !q.sys_rst) |=>
		(sys_reset_o && q.cause[`RC_FLASH_ERROR_BIT] && !stall_o))
		else $error("Locked flash attempt did not raise a flash error reset.");

	chk_relock_after_op: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		$fell(stall_o) && !sys_reset_o |-> q.key == KEY_IDLE)
		else $error("Key logic not relocked after a flash operation.");

	chk_route_data_mem: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		(ext_move_wr_i && !q.wr_en && !q.sys_rst && !(|{watchdog_reset_i,
		vdd_low_i, wr_cause, !q.pin_sync, clock_missing_i && q.mcd_en,
		comparator_trip_i && q.cmp_en})) |=>
		(xram_we_o && xram_addr_o == $past(ext_move_addr_i)))
		else $error("Move write with write enable clear missed data memory.");

	chk_no_xram_when_armed: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		ext_move_wr_i && q.wr_en |=> !xram_we_o)
		else $error("Move write reached data memory while write enabled.");

	chk_enable_survives: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		$fell(stall_o) && !sys_reset_o && !$past(wr_ctrl) |-> q.wr_en)
		else $error("Write enable dropped when an operation finished.");

	chk_write_stall_time: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		$rose(stall_o) && !q.is_erase |-> stall_o[*8])
		else $error("Stall released early during a byte write.");

	chk_stall_count: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		$rose(stall_o) |-> q.cnt == (q.is_erase ? ERASE_LAST : WRITE_LAST))
		else $error("Operation timer loaded with the wrong count.");

	chk_erase_start: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		(flash_try && q.key == KEY_OPEN && q.erase_en && !q.sys_rst &&
		!(|{watchdog_reset_i, vdd_low_i, wr_cause, !q.pin_sync,
		clock_missing_i && q.mcd_en, comparator_trip_i && q.cmp_en})) |=>
		(q.flash_erase && q.is_erase && stall_o &&
		q.flash_addr == $past(ext_move_addr_i[ADDR_W-1:0])))
		else $error("Armed erase write did not start a page erase.");

	chk_software_reset: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		(wr_cause && sfr_wdata_i[`RC_SOFTWARE_BIT] && !q.sys_rst) |=>
		(sys_reset_o && q.cause[`RC_SOFTWARE_BIT]) [*4])
		else $error("Software reset bit did not force a system reset.");

	chk_reset_clears_key: assert property (
		@(posedge clk_i) disable iff (!rst_n)
		sys_reset_o |-> (q.key == KEY_IDLE && !q.wr_en && !stall_o))
		else $error("System reset left key or enable state behind.");

endmodule // flash_write_erase_control
`default_nettype wire

// ==== bench/cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// CPU core on the far side: one request at a time, held off while stalled.
module cpu_model (
	input wire logic clk_i,
	input wire logic stall_i,
	input wire logic [7:0] sfr_rdata_i,
	output logic sfr_wr_o,
	output logic sfr_rd_o,
	output logic [7:0] sfr_addr_o,
	output logic [7:0] sfr_wdata_o,
	output logic ext_move_wr_o,
	output logic [15:0] ext_move_addr_o,
	output logic [7:0] ext_move_data_o,
	output logic hung_o
);
	// The bus idles at time zero.
	initial begin
		sfr_wr_o = 1'b0;
		sfr_rd_o = 1'b0;
		sfr_addr_o = 8'h00;
		sfr_wdata_o = 8'h00;
		ext_move_wr_o = 1'b0;
		ext_move_addr_o = 16'h0000;
		ext_move_data_o = 8'h00;
		hung_o = 1'b0;
	end

	// No instruction issues while the core is stalled.
	task automatic start();
		int n;
		n = 0;
		@(posedge clk_i);
		#1;
		while (stall_i === 1'b1 && n < 5000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n >= 5000) hung_o = 1'b1;
	endtask

	// Released address and data lines show the inverse so a stale value is never reused.
	task automatic sfr_access(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		start();
		sfr_wr_o = wr;
		sfr_rd_o = ~wr;
		sfr_addr_o = a;
		sfr_wdata_o = d;
		@(posedge clk_i);
		#1;
		q = sfr_rdata_i;
		sfr_wr_o = 1'b0;
		sfr_rd_o = 1'b0;
		sfr_addr_o = ~a;
		sfr_wdata_o = ~d;
	endtask

	// Whole-byte writes only, never read-modify-write.
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		sfr_access(1'b1, a, d, q);
	endtask

	task automatic sfr_read(input logic [7:0] a, output logic [7:0] q);
		sfr_access(1'b0, a, 8'h00, q);
	endtask

	// One byte per external move write, address and data as operands.
	task automatic move_write(input logic [15:0] a, input logic [7:0] d);
		start();
		ext_move_wr_o = 1'b1;
		ext_move_addr_o = a;
		ext_move_data_o = d;
		@(posedge clk_i);
		#1;
		ext_move_wr_o = 1'b0;
		ext_move_addr_o = ~a;
		ext_move_data_o = ~d;
	endtask
endmodule // cpu_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_write_erase_control_defines.svh"
module tb_top;
	localparam int ERASE = 20;
	logic clk_i = 1'b0, reset_n_i = 1'b0, wdog = 1'b0, stall, sys_rst;
	logic pin_n = 1'b1, vdd_low = 1'b0;
	logic sfr_wr, sfr_rd, mv_wr, xwe, hung;
	logic [7:0] sfr_addr, sfr_wdata, rdata, mv_data, xdata, cdata, xd;
	logic [15:0] mv_addr, xaddr, xa;
	logic [9:0] caddr = 10'h000;
	int bad_count = 0, checks = 0, xcount = 0;

	// Clock at 20 MHz.
	always #25 clk_i = ~clk_i;

	cpu_model cpu (.clk_i(clk_i), .stall_i(stall), .sfr_rdata_i(rdata),
		.sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd), .sfr_addr_o(sfr_addr),
		.sfr_wdata_o(sfr_wdata), .ext_move_wr_o(mv_wr),
		.ext_move_addr_o(mv_addr), .ext_move_data_o(mv_data),
		.hung_o(hung));

	// Shortened erase so the run stays brief; the byte write time is fixed.
	flash_write_erase_control #(.ADDR_W(10), .PAGE_W(9),
		.ERASE_CYCLES(ERASE)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.pin_reset_n_i(pin_n), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
		.sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(rdata),
		.ext_move_wr_i(mv_wr), .ext_move_addr_i(mv_addr),
		.ext_move_data_i(mv_data), .xram_we_o(xwe), .xram_addr_o(xaddr),
		.xram_data_o(xdata), .code_addr_i(caddr), .code_data_o(cdata),
		.watchdog_reset_i(wdog), .clock_missing_i(1'b0),
		.comparator_trip_i(1'b0), .vdd_low_i(vdd_low), .stall_o(stall),
		.sys_reset_o(sys_rst));

	// Data-memory writes are logged for later comparison.
	always @(posedge clk_i) if (xwe === 1'b1) begin
		xcount++;
		xa = xaddr;
		xd = xdata;
	end

	always @(posedge hung) begin
		bad_count++;
		print_verdict();
	end

	task automatic print_verdict();
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_count(input int got, input int exp);
		checks++;
		if (got != exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic step();
		@(posedge clk_i);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		cpu.sfr_read(a, q);
		chk_byte(q, exp);
	endtask

	task automatic code(input logic [9:0] a, input logic [7:0] exp);
		step();
		caddr = a;
		step();
		chk_byte(cdata, exp);
	endtask

	// Count the stall cycles of one flash operation, bounded.
	task automatic stall_len(input int exp);
		int n;
		n = 0;
		while (stall === 1'b1 && n < 5000) begin
			n++;
			step();
		end
		chk_count(n, exp);
	endtask

	task automatic unlock();
		cpu.sfr_write(`SFR_FLASH_UNLOCK_KEY, `KEY_FIRST_CODE);
		cpu.sfr_write(`SFR_FLASH_UNLOCK_KEY, `KEY_SECOND_CODE);
	endtask

	task automatic flash_op(input logic [15:0] a, input logic [7:0] d,
		input int cyc);
		unlock();
		cpu.move_write(a, d);
		stall_len(cyc);
	endtask

	// A system reset must come, last four cycles and then clear.
	task automatic sysreset_wait();
		int n;
		int m;
		n = 0;
		m = 0;
		while (sys_rst !== 1'b1 && n < 20) begin
			n++;
			step();
		end
		while (sys_rst === 1'b1 && m < 20) begin
			m++;
			step();
		end
		chk_count(m, 4);
		if (n >= 20) print_verdict();
		repeat (2) step();
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		#1;
		reset_n_i = 1'b1;
		repeat (3) step();
		rd(`SFR_RESET_CAUSE, `RC_RESET_VALUE);
		rd(`SFR_FLASH_UNLOCK_KEY, `KEY_READ_IDLE);
		// With write enable clear a move write lands in data memory.
		cpu.move_write(16'h1234, 8'h77);
		step();
		chk_count(xcount, 1);
		chk_byte(xa[15:8], 8'h12);
		chk_byte(xa[7:0], 8'h34);
		chk_byte(xd, 8'h77);
		// Byte programming, key progress visible at each step.
		cpu.sfr_write(`SFR_PROGRAM_STORE_CONTROL, 8'h01);
		cpu.sfr_write(`SFR_FLASH_UNLOCK_KEY, `KEY_FIRST_CODE);
		rd(`SFR_FLASH_UNLOCK_KEY, `KEY_READ_FIRST);
		cpu.sfr_write(`SFR_FLASH_UNLOCK_KEY, `KEY_SECOND_CODE);
		rd(`SFR_FLASH_UNLOCK_KEY, `KEY_READ_OPEN);
		cpu.move_write(16'h0010, 8'h5a);
		stall_len(800);
		rd(`SFR_FLASH_UNLOCK_KEY, `KEY_READ_IDLE);
		rd(`SFR_PROGRAM_STORE_CONTROL, 8'h01);
		code(10'h010, 8'h5a);
		code(10'h011, 8'hff);
		flash_op(16'h0010, 8'h0f, 800);
		code(10'h010, 8'h0a);
		flash_op(16'h0200, 8'h3c, 800);
		chk_count(xcount, 1);
		// Page erase from its last byte; the next page must survive.
		cpu.sfr_write(`SFR_PROGRAM_STORE_CONTROL, 8'h03);
		flash_op(16'h01ff, 8'h00, ERASE);
		cpu.sfr_write(`SFR_PROGRAM_STORE_CONTROL, 8'h00);
		code(10'h010, 8'hff);
		code(10'h000, 8'hff);
		code(10'h200, 8'h3c);
		// Wrong first code, then a correct pair stays locked out.
		cpu.sfr_write(`SFR_FLASH_UNLOCK_KEY, `KEY_SECOND_CODE);
		unlock();
		rd(`SFR_FLASH_UNLOCK_KEY, `KEY_READ_LOCKOUT);
		cpu.sfr_write(`SFR_RESET_CAUSE, 8'h12);
		sysreset_wait();
		rd(`SFR_RESET_CAUSE, 8'h10);
		rd(`SFR_FLASH_UNLOCK_KEY, `KEY_READ_IDLE);
		// Wrong second code, then an attempt on the locked flash.
		cpu.sfr_write(`SFR_FLASH_UNLOCK_KEY, `KEY_FIRST_CODE);
		cpu.sfr_write(`SFR_FLASH_UNLOCK_KEY, `KEY_FIRST_CODE);
		rd(`SFR_FLASH_UNLOCK_KEY, `KEY_READ_LOCKOUT);
		cpu.sfr_write(`SFR_PROGRAM_STORE_CONTROL, 8'h01);
		cpu.move_write(16'h0020, 8'h00);
		sysreset_wait();
		rd(`SFR_RESET_CAUSE, 8'h40);
		code(10'h020, 8'hff);
		rd(`SFR_FLASH_UNLOCK_KEY, `KEY_READ_IDLE);
		// A flash write with no key at all.
		cpu.sfr_write(`SFR_PROGRAM_STORE_CONTROL, 8'h01);
		cpu.move_write(16'h0030, 8'h00);
		sysreset_wait();
		rd(`SFR_RESET_CAUSE, 8'h40);
		code(10'h030, 8'hff);
		// A watchdog reset leaves the flash error flag clear.
		wdog = 1'b1;
		step();
		wdog = 1'b0;
		sysreset_wait();
		rd(`SFR_RESET_CAUSE, 8'h08);
		// A pin pulse and a supply dip each reset and name their own cause.
		pin_n = 1'b0;
		step();
		pin_n = 1'b1;
		sysreset_wait();
		rd(`SFR_RESET_CAUSE, 8'h01);
		vdd_low = 1'b1;
		step();
		vdd_low = 1'b0;
		sysreset_wait();
		rd(`SFR_RESET_CAUSE, 8'h02);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
